// ==== verilog/cbe_branch_unit.sv ====
// conditional relative branch sequencer with program counter update
// assumes decoder issues on issue_in only when ready_out is high
// assumes the status register is owned elsewhere; this block never writes it
`timescale 1ns/1ps
`default_nettype none
`include "cbe_regs.svh"
// How it works
// - taken loads pc plus offset plus one
// - one cycle not taken, two taken
// - branches never change any status flag
// - lower branches when carry is one
// - minus branches when negative is one
// - plus branches when negative is zero
// - signed ge branches when n xor v zero
// - signed lt branches when n xor v one
// - halfcarry set branches when h one
// - halfcarry clear branches when h zero
// - transfer set branches when t one
// - same or higher branches when carry zero
module cbe_branch_unit #(
  parameter int PC_WIDTH = 16,
  parameter int OFFSET_WIDTH = 7
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // decoder side
  input wire logic issue_in,
  input wire cbe_pkg::cbe_cond_t cond_in,
  input wire logic [OFFSET_WIDTH-1:0] offset_in,
  output logic ready_out,
  // status register side
  input wire logic [7:0] sreg_in,
  output logic sreg_we_out,
  // program counter
  output logic [PC_WIDTH-1:0] pc_out,
  output logic done_out,
  output logic taken_out
);
  import cbe_pkg::*;

  // refuse widths the adder cannot serve; the extension needs at least one bit to copy into
  if (PC_WIDTH < 2 || OFFSET_WIDTH < 1 || OFFSET_WIDTH >= PC_WIDTH) begin : g_bad_width
    $error("cbe_branch_unit: bad width parameters");
  end

  cbe_state_t state; // sequencer state
  cbe_state_t next_state;
  logic [PC_WIDTH-1:0] pc; // program counter
  logic [PC_WIDTH-1:0] next_pc;
  logic [PC_WIDTH-1:0] target; // held target for the second cycle
  logic done; // completion pulse
  logic done_taken; // completion was a taken branch
  wire logic cond_true; // evaluated condition

  // condition test lives in its own leaf
  cbe_cond_eval i_cbe_cond_eval (
    .cond_in(cond_in),
    .sreg_in(sreg_in),
    .taken_out(cond_true)
  );

  // offset sign extended before addition, so backward branches wrap right
  wire logic [PC_WIDTH-1:0] offset_ext =
    {{(PC_WIDTH-OFFSET_WIDTH){offset_in[OFFSET_WIDTH-1]}}, offset_in};
  wire logic [PC_WIDTH-1:0] pc_plus_one = pc + {{(PC_WIDTH-1){1'b0}}, 1'b1};
  wire logic [PC_WIDTH-1:0] branch_target = pc_plus_one + offset_ext;
  wire logic accept = issue_in && (state == CBE_FETCH);
  wire logic take = accept && cond_true && (cond_in != CBE_NONE);

  // flags are read only; the write enable stays low for every branch
  assign sreg_we_out = 1'b0;
  // no new issue while the taken branch spends its second cycle
  assign ready_out = (state == CBE_FETCH);

  // next state and pc
  always_comb begin
    next_state = state;
    next_pc = pc;
    unique case (state)
      CBE_FETCH: begin
        if (take) begin
          next_state = CBE_TAKEN_WAIT;
        end else if (accept) begin
          next_pc = pc_plus_one; // falls through in one cycle
        end
      end
      CBE_TAKEN_WAIT: begin
        next_state = CBE_FETCH;
        next_pc = target; // target loaded in second cycle
      end
    endcase
  end

  // state and pc registers
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state <= CBE_FETCH;
      pc <= `CBE_PC_RESET;
    end else begin
      state <= next_state;
      pc <= next_pc;
    end
  end

  // target capture at issue
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      target <= `CBE_PC_RESET;
    end else if (take) begin
      target <= branch_target;
    end
  end

  // completion pulse, one per branch
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      done <= 1'b0;
      done_taken <= 1'b0;
    end else begin
      done <= (accept && !take) || (state == CBE_TAKEN_WAIT);
      done_taken <= (state == CBE_TAKEN_WAIT);
    end
  end

  assign pc_out = pc;
  assign done_out = done;
  assign taken_out = done_taken;

  // helper: marks that at least one cycle has passed since reset, so $past values are valid
  logic hist_valid;
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      hist_valid <= 1'b0;
    end else begin
      hist_valid <= 1'b1;
    end
  end

  sequence s_taken_issue;
    accept && take;
  endsequence
  sequence s_fall_issue;
    accept && !take;
  endsequence

  chk_taken_two_cycles: assert property (
    @(posedge clk_in) disable iff (srst_in)
    s_taken_issue |=> !ready_out ##1 ready_out && done_out && taken_out)
    else $error("taken branch did not take two cycles");

  chk_fall_one_cycle: assert property (
    @(posedge clk_in) disable iff (srst_in)
    s_fall_issue |=> ready_out && done_out && !taken_out)
    else $error("not taken branch did not take one cycle");

  chk_taken_target: assert property (
    @(posedge clk_in) disable iff (srst_in)
    s_taken_issue |-> ##2 pc_out == $past(branch_target, 2))
    else $error("taken branch loaded wrong target");

  chk_fall_next: assert property (
    @(posedge clk_in) disable iff (srst_in)
    s_fall_issue |=> pc_out == PC_WIDTH'($past(pc) + 1'b1))
    else $error("not taken branch did not advance by one");

  chk_flags_kept: assert property (
    @(posedge clk_in) disable iff (srst_in)
    !sreg_we_out)
    else $error("branch wrote the status register");

  chk_pc_holds_idle: assert property (
    @(posedge clk_in) disable iff (srst_in)
    hist_valid && $past(state) == CBE_FETCH && !$past(issue_in) |-> $stable(pc_out))
    else $error("pc moved without an issue");

  chk_carry_lower: assert property (
    @(posedge clk_in) disable iff (srst_in)
    accept && cond_in == CBE_BRANCH_IF_LOWER |-> take == sreg_in[`CBE_FLAG_C])
    else $error("lower branch disagrees with carry");

  chk_carry_same_higher: assert property (
    @(posedge clk_in) disable iff (srst_in)
    accept && cond_in == CBE_BRANCH_IF_SAME_OR_HIGHER |-> take == !sreg_in[`CBE_FLAG_C])
    else $error("same or higher branch disagrees with carry");

  chk_signed_lt: assert property (
    @(posedge clk_in) disable iff (srst_in)
    accept && cond_in == CBE_BRANCH_IF_SIGNED_LT |->
      take == (sreg_in[`CBE_FLAG_N] ^ sreg_in[`CBE_FLAG_V]))
    else $error("signed lt branch disagrees with n xor v");

  chk_signed_ge: assert property (
    @(posedge clk_in) disable iff (srst_in)
    accept && cond_in == CBE_BRANCH_IF_SIGNED_GE |->
      take == !(sreg_in[`CBE_FLAG_N] ^ sreg_in[`CBE_FLAG_V]))
    else $error("signed ge branch disagrees with n xor v");

  chk_minus_plus: assert property (
    @(posedge clk_in) disable iff (srst_in)
    accept && (cond_in == CBE_BRANCH_IF_MINUS || cond_in == CBE_BRANCH_IF_PLUS) |->
      take == (sreg_in[`CBE_FLAG_N] == (cond_in == CBE_BRANCH_IF_MINUS)))
    else $error("minus or plus branch disagrees with negative");

  chk_halfcarry: assert property (
    @(posedge clk_in) disable iff (srst_in)
    accept && (cond_in == CBE_BRANCH_IF_HALFCARRY_SET ||
      cond_in == CBE_BRANCH_IF_HALFCARRY_CLEAR) |->
      take == (sreg_in[`CBE_FLAG_H] == (cond_in == CBE_BRANCH_IF_HALFCARRY_SET)))
    else $error("halfcarry branch disagrees with h");

  chk_transfer_set: assert property (
    @(posedge clk_in) disable iff (srst_in)
    accept && cond_in == CBE_BRANCH_IF_TRANSFER_SET |-> take == sreg_in[`CBE_FLAG_T])
    else $error("transfer branch disagrees with t");

  // the jump distance seen on the pc must equal the signed offset, end to end
  chk_offset_sign: assert property (
    @(posedge clk_in) disable iff (srst_in)
    s_taken_issue |-> ##2
      $signed(PC_WIDTH'(pc_out - $past(pc, 2) - 1'b1)) == $signed($past(offset_in, 2)))
    else $error("offset not sign extended");
endmodule : cbe_branch_unit
`default_nettype wire

// ==== verilog/cbe_regs.svh ====
// constants for the conditional branch evaluator
// assumes inclusion by bare name from the design files
`ifndef CBE_REGS_SVH
`define CBE_REGS_SVH
// status flag bit positions in the status byte
`define CBE_FLAG_C 0
`define CBE_FLAG_N 2
`define CBE_FLAG_V 3
`define CBE_FLAG_H 5
`define CBE_FLAG_T 6
// cycle counts of a conditional branch
`define CBE_CYC_NOT_TAKEN 1
`define CBE_CYC_TAKEN 2
// reset value of the program counter
`define CBE_PC_RESET 16'h0000
`endif

// ==== verilog/cbe_pkg.sv ====
// types for the conditional branch evaluator
// assumes nothing beyond a systemverilog compiler
package cbe_pkg;
  // branch condition selected by the decoder
  typedef enum logic [3:0] {
    CBE_NONE,
    CBE_BRANCH_IF_LOWER,
    CBE_BRANCH_IF_SAME_OR_HIGHER,
    CBE_BRANCH_IF_MINUS,
    CBE_BRANCH_IF_PLUS,
    CBE_BRANCH_IF_SIGNED_GE,
    CBE_BRANCH_IF_SIGNED_LT,
    CBE_BRANCH_IF_HALFCARRY_SET,
    CBE_BRANCH_IF_HALFCARRY_CLEAR,
    CBE_BRANCH_IF_TRANSFER_SET
  } cbe_cond_t;
  // sequencer states
  typedef enum logic [0:0] {
    CBE_FETCH,
    CBE_TAKEN_WAIT
  } cbe_state_t;
endpackage : cbe_pkg

// ==== verilog/cbe_cond_eval.sv ====
// combinational test of one branch condition against the status byte
// assumes the status byte is stable during the issue cycle
`timescale 1ns/1ps
`default_nettype none
`include "cbe_regs.svh"
module cbe_cond_eval (
  // selection and flags
  input wire cbe_pkg::cbe_cond_t cond_in,
  input wire logic [7:0] sreg_in,
  // result
  output logic taken_out
);
  import cbe_pkg::*;
  // individual flags picked from the status byte
  wire logic flag_c = sreg_in[`CBE_FLAG_C];
  wire logic flag_n = sreg_in[`CBE_FLAG_N];
  wire logic flag_v = sreg_in[`CBE_FLAG_V];
  wire logic flag_h = sreg_in[`CBE_FLAG_H];
  wire logic flag_t = sreg_in[`CBE_FLAG_T];
  // signed relation is sign xor overflow
  wire logic signed_less = flag_n ^ flag_v;
  // condition multiplexer
  always_comb begin
    unique case (cond_in)
      CBE_NONE: taken_out = 1'b0;
      CBE_BRANCH_IF_LOWER: taken_out = flag_c;
      CBE_BRANCH_IF_SAME_OR_HIGHER: taken_out = ~flag_c;
      CBE_BRANCH_IF_MINUS: taken_out = flag_n;
      CBE_BRANCH_IF_PLUS: taken_out = ~flag_n;
      CBE_BRANCH_IF_SIGNED_GE: taken_out = ~signed_less;
      CBE_BRANCH_IF_SIGNED_LT: taken_out = signed_less;
      CBE_BRANCH_IF_HALFCARRY_SET: taken_out = flag_h;
      CBE_BRANCH_IF_HALFCARRY_CLEAR: taken_out = ~flag_h;
      CBE_BRANCH_IF_TRANSFER_SET: taken_out = flag_t;
      default: taken_out = 1'b0; // illegal code never branches
    endcase
  end
endmodule : cbe_cond_eval
`default_nettype wire

// ==== bench/cbe_branch_unit_tb_top.sv ====
// self-checking bench for the conditional branch sequencer
// assumes cbe_pkg and cbe_regs.svh are compiled ahead; inputs move on falling edges
`timescale 1ns/1ps
`default_nettype none
`include "cbe_regs.svh"
module cbe_branch_unit_tb_top;
  import cbe_pkg::*;
  // clock and reset
  logic clk_in;
  logic srst_in;
  // decoder side stimulus
  logic issue_in;
  cbe_cond_t cond_in;
  logic [6:0] offset_in;
  logic [7:0] sreg_in;
  // observed outputs
  logic ready_out;
  logic sreg_we_out;
  logic [15:0] pc_out;
  logic done_out;
  logic taken_out;
  // bookkeeping
  int fail_count;
  int checks;
  logic [15:0] pc_model; // where the program counter should be now

  cbe_branch_unit #(.PC_WIDTH(16), .OFFSET_WIDTH(7)) i_cbe_branch_unit (
    .clk_in(clk_in), .srst_in(srst_in), .issue_in(issue_in), .cond_in(cond_in),
    .offset_in(offset_in), .ready_out(ready_out), .sreg_in(sreg_in),
    .sreg_we_out(sreg_we_out), .pc_out(pc_out), .done_out(done_out), .taken_out(taken_out)
  );

  // free-running core clock, 5 ns period
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  // single comparison point, four-state exact
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // verdict and end of run
  task automatic conclude();
    $display("checks %0d, mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : conclude

  // expected outcome worked out independently from the flag positions
  function automatic logic want_taken(input cbe_cond_t c, input logic [7:0] s);
    case (c)
      CBE_BRANCH_IF_LOWER: return s[`CBE_FLAG_C];
      CBE_BRANCH_IF_SAME_OR_HIGHER: return !s[`CBE_FLAG_C];
      CBE_BRANCH_IF_MINUS: return s[`CBE_FLAG_N];
      CBE_BRANCH_IF_PLUS: return !s[`CBE_FLAG_N];
      CBE_BRANCH_IF_SIGNED_GE: return !(s[`CBE_FLAG_N] ^ s[`CBE_FLAG_V]);
      CBE_BRANCH_IF_SIGNED_LT: return s[`CBE_FLAG_N] ^ s[`CBE_FLAG_V];
      CBE_BRANCH_IF_HALFCARRY_SET: return s[`CBE_FLAG_H];
      CBE_BRANCH_IF_HALFCARRY_CLEAR: return !s[`CBE_FLAG_H];
      CBE_BRANCH_IF_TRANSFER_SET: return s[`CBE_FLAG_T];
      default: return 1'b0; // no condition never branches
    endcase
  endfunction : want_taken

  // one branch, entered on a falling edge; leaves issue_in high for back-to-back use
  task automatic run(input cbe_cond_t c, input logic [7:0] s, input logic [6:0] k);
    logic t;
    logic [15:0] exp_pc;
    t = want_taken(c, s);
    exp_pc = t ? pc_model + 16'h0001 + {{9{k[6]}}, k} : pc_model + 16'h0001;
    issue_in = 1'b1;
    cond_in = c;
    sreg_in = s;
    offset_in = k;
    @(negedge clk_in);
    if (t) begin
      // refused issue with other inputs while busy must have no effect
      cond_in = CBE_NONE;
      offset_in = ~k;
      sreg_in = ~s;
      check(ready_out, 16'h0000);
      check(done_out, 16'h0000);
      check(pc_out, pc_model);
      check(sreg_we_out, 16'h0000);
      @(negedge clk_in);
    end
    check(done_out, 16'h0001);
    check(taken_out, {15'h0000, t});
    check(pc_out, exp_pc);
    check(ready_out, 16'h0001);
    check(sreg_we_out, 16'h0000);
    pc_model = exp_pc;
  endtask : run

  // every condition, plus one illegal code, against flag patterns, back to back
  task automatic sweep();
    logic [7:0] pats [6];
    pats = '{8'h00, 8'hFF, 8'h04, 8'h08, 8'h21, 8'h40};
    for (int i = 0; i < 11; i++) begin
      for (int j = 0; j < 6; j++) begin
        run(cbe_cond_t'(i), pats[j], 7'(i * 13 + j * 29));
      end
    end
  endtask : sweep

  // with no issue the counter holds and no completion appears
  task automatic idle();
    issue_in = 1'b0;
    repeat (3) @(negedge clk_in);
    check(pc_out, pc_model);
    check(done_out, 16'h0000);
  endtask : idle

  // reset in the middle of a taken branch, then a minus-one offset from zero
  task automatic reset_mid();
    cond_in = CBE_BRANCH_IF_LOWER;
    sreg_in = 8'hFF;
    offset_in = 7'h05;
    issue_in = 1'b1;
    @(negedge clk_in);
    srst_in = 1'b1;
    issue_in = 1'b0;
    @(negedge clk_in);
    check(pc_out, `CBE_PC_RESET);
    check(ready_out, 16'h0001);
    check(done_out, 16'h0000);
    check(taken_out, 16'h0000);
    srst_in = 1'b0;
    pc_model = `CBE_PC_RESET;
    run(CBE_BRANCH_IF_PLUS, 8'h00, 7'h7F);
  endtask : reset_mid

  // main sequence
  initial begin
    fail_count = 0;
    checks = 0;
    pc_model = `CBE_PC_RESET;
    srst_in = 1'b1;
    issue_in = 1'b0;
    cond_in = CBE_NONE;
    offset_in = 7'h00;
    sreg_in = 8'h00;
    repeat (4) @(negedge clk_in);
    check(pc_out, `CBE_PC_RESET);
    check(ready_out, 16'h0001);
    srst_in = 1'b0;
    sweep();
    idle();
    reset_mid();
    conclude();
  end

  // watchdog: the sequence needs well under 300 cycles
  initial begin
    #(5 * 2000);
    fail_count++;
    conclude();
  end
endmodule : cbe_branch_unit_tb_top
`default_nettype wire
